//--- core/msx_mem_space.sv
// Purpose: Memory space decoder for internal, indirect, auxiliary and code spaces.
// Assumes: The core issues one access per cycle; read data returns one cycle later.
// Notes: Special register space is outside this block; direct upper accesses go there.
//
// Operation
// R1: Extended registers are real storage reached by data-pointer external moves.
// R2: Power-on reset loads brownout interrupt trip bits from config byte1 bits 5,3.
// R3: Reset loads clock control oscillator select bits from config byte1 bits 2..0.
// R4: Reset loads clock doubler bit from config byte2 bit 7.
// R5: Low 128 bytes reachable by direct and indirect ordinary accesses.
// R6: Indirect space spans 256 bytes, only through indirect addressing.
// R7: Indirect low half shares storage with the direct area.
// R8: Direct upper accesses go to special registers; indirect upper go to RAM.
// R9: Auxiliary space is 64 kB, addressed by data pointer or pointer reg 0/1.
// R10: Auxiliary space holds 512 bytes of RAM plus the extended registers.
// R11: Code space is 64 kB, for fetch and code moves; on-chip part sized by parameter.
// R12: Extended register hits do not touch auxiliary RAM.
`timescale 1ns/1ps
module msx_mem_space #(
  parameter int AUX_BYTES  = msx_pkg::AUX_RAM_BYTES,
  parameter int CODE_SIZE  = msx_pkg::CODE_BYTES
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        por_flag,
  input  wire logic [7:0]  user_config_byte1,
  input  wire logic [7:0]  user_config_byte2,
  input  wire logic        clk_ok,
  input  wire logic        xtal_wd,
  input  wire logic        iram_req,
  input  wire logic        iram_indirect,
  input  wire logic        iram_we,
  input  wire logic [7:0]  iram_addr,
  input  wire logic [7:0]  iram_wdata,
  output logic [7:0]       iram_rdata,
  output logic             sfr_sel,
  input  wire logic        aux_req,
  input  wire logic        aux_we,
  input  wire logic        aux_use_ptr,
  input  wire logic        aux_ptr_sel,
  input  wire logic [15:0] data_pointer,
  input  wire logic [7:0]  pointer_reg0,
  input  wire logic [7:0]  pointer_reg1,
  input  wire logic [7:0]  aux_page,
  input  wire logic [7:0]  aux_wdata,
  output logic [7:0]       aux_rdata,
  input  wire logic        code_req,
  input  wire logic        code_we,
  input  wire logic [15:0] code_addr,
  input  wire logic [7:0]  code_wdata,
  output logic [7:0]       code_rdata,
  output logic [7:0]       clock_control_reg,
  output logic [7:0]       temp_sensor_ctrl,
  output logic [1:0]       bod_irq_trip_cfg
);
  localparam int AW = $clog2(AUX_BYTES);
  localparam int CW = $clog2(CODE_SIZE);

  logic [7:0]  iram_mem [msx_pkg::IRAM_BYTES];
  logic [7:0]  aux_mem  [AUX_BYTES];
  logic [7:0]  code_mem [CODE_SIZE];
  logic [15:0] aux_addr;
  logic        ext_hit, ext_we, aux_ram_hit, iram_ok, code_ok;
  logic [7:0]  ext_rdata, ext_ccr, ext_tps;
  logic [1:0]  ext_bod;
  logic [7:0]  iram_rdata_d, iram_rdata_q, aux_rdata_d, aux_rdata_q, code_rdata_d, code_rdata_q;
  logic [7:0]  ccr_q, tps_q;
  logic [1:0]  bod_q;
  logic        sfr_sel_d, sfr_sel_q;
  logic        iram_wr, aux_wr, code_wr;
  logic [1:0]  pin_s1_d, pin_s1_q, pin_s2_d, pin_s2_q, pin_s3_d, pin_s3_q, pin_q;
  wire  [1:0]  pin_d;

  // Oscillator status comes from another clock; a change counts once the last two stages agree.
  always_comb
  begin
    pin_s1_d = {clk_ok, xtal_wd};
    pin_s2_d = pin_s1_q;
    pin_s3_d = pin_s2_q;
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_pin
    assign pin_d[g] = (pin_s2_q[g] == pin_s3_q[g]) ? pin_s3_q[g] : pin_q[g];
  end

  always_comb
  begin
    aux_addr = aux_use_ptr ? {aux_page, (aux_ptr_sel ? pointer_reg1 : pointer_reg0)} : data_pointer; // R9
    ext_we = aux_req && aux_we && !aux_use_ptr; // R1
    aux_ram_hit = aux_req && !(ext_hit && !aux_use_ptr) && (aux_addr < 16'(AUX_BYTES)); // R10 R12
    iram_ok = iram_req && (iram_indirect || !iram_addr[7]); // R5 R6 R7
    sfr_sel_d = iram_req && !iram_indirect && iram_addr[7]; // R8
    code_ok = code_req && (code_addr < 16'(CODE_SIZE)); // R11
    iram_wr = iram_ok && iram_we; // R7
    aux_wr = aux_ram_hit && aux_we; // R12
    code_wr = code_ok && code_we;
    iram_rdata_d = iram_ok ? iram_mem[iram_addr] : 8'h00;
    if (aux_req && ext_hit && !aux_use_ptr)
      aux_rdata_d = ext_rdata; // R1
    else if (aux_ram_hit)
      aux_rdata_d = aux_mem[aux_addr[AW-1:0]];
    else
      aux_rdata_d = 8'h00;
    code_rdata_d = code_ok ? code_mem[code_addr[CW-1:0]] : 8'hff;
  end

  always_ff @(posedge clk_sys)
  begin
    if (iram_wr)
      iram_mem[iram_addr] <= iram_wdata; // R7
    if (aux_wr)
      aux_mem[aux_addr[AW-1:0]] <= aux_wdata; // R12
    if (code_wr)
      code_mem[code_addr[CW-1:0]] <= code_wdata;
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      iram_rdata_q <= 8'h00;
      aux_rdata_q <= 8'h00;
      code_rdata_q <= 8'h00;
      sfr_sel_q <= 1'b0;
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
      pin_q <= 2'h0;
      ccr_q <= 8'h00;
      tps_q <= 8'h00;
      bod_q <= 2'h0;
    end
    else
    begin
      iram_rdata_q <= iram_rdata_d;
      aux_rdata_q <= aux_rdata_d;
      code_rdata_q <= code_rdata_d;
      sfr_sel_q <= sfr_sel_d;
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
      pin_s3_q <= pin_s3_d;
      pin_q <= pin_d;
      ccr_q <= ext_ccr;
      tps_q <= ext_tps;
      bod_q <= ext_bod;
    end
  end

  msx_ext_regs u_ext (
    .clk_sys           (clk_sys),
    .reset             (reset),
    .por_flag          (por_flag),
    .user_config_byte1 (user_config_byte1),
    .user_config_byte2 (user_config_byte2),
    .clk_ok            (pin_q[1]),
    .xtal_wd           (pin_q[0]),
    .addr              (data_pointer),
    .wr_en             (ext_we),
    .wdata             (aux_wdata),
    .hit               (ext_hit),
    .rdata             (ext_rdata),
    .clock_control_reg (ext_ccr),
    .temp_sensor_ctrl  (ext_tps),
    .bod_irq_trip_cfg  (ext_bod)
  );

  assign iram_rdata = iram_rdata_q;
  assign aux_rdata = aux_rdata_q;
  assign code_rdata = code_rdata_q;
  assign sfr_sel = sfr_sel_q;
  assign clock_control_reg = ccr_q;
  assign temp_sensor_ctrl = tps_q;
  assign bod_irq_trip_cfg = bod_q;

  a_direct_upper_sfr: assert property (@(posedge clk_sys) disable iff (reset) // R8
    (iram_req && !iram_indirect && iram_addr[7]) |=> sfr_sel && iram_rdata == 8'h00)
    else $error("direct upper access not sent to special registers");
  a_direct_low_ram: assert property (@(posedge clk_sys) disable iff (reset) // R5
    (iram_req && !iram_addr[7]) |=> !sfr_sel) else $error("low area access sent to special registers");
  a_indirect_upper_ram: assert property (@(posedge clk_sys) disable iff (reset) // R6
    (iram_req && iram_indirect) |=> !sfr_sel) else $error("indirect access sent to special registers");
  a_shared_low_half: assert property (@(posedge clk_sys) disable iff (reset) // R5 R7
    (iram_req && iram_we && !iram_addr[7]) ##1 (iram_req && !iram_we && iram_indirect
      && iram_addr == $past(iram_addr)) |=> iram_rdata == $past(iram_wdata, 2))
    else $error("direct and indirect low area differ");
  a_shared_gap: assert property (@(posedge clk_sys) disable iff (reset) // R5 R7
    (iram_req && iram_we && !iram_addr[7]) ##1 !iram_req ##1 (iram_req && !iram_we && iram_indirect
      && iram_addr == $past(iram_addr, 2)) |=> iram_rdata == $past(iram_wdata, 3))
    else $error("low area write not seen by indirect read");
  a_iram_idle_zero: assert property (@(posedge clk_sys) disable iff (reset)
    !iram_req |=> iram_rdata == 8'h00) else $error("idle internal read not zero");
  a_ext_no_ram: assert property (@(posedge clk_sys) disable iff (reset) // R12
    (aux_req && !aux_use_ptr && ext_hit) |-> !aux_ram_hit) else $error("extended hit touched RAM");
  a_ptr_no_ext: assert property (@(posedge clk_sys) disable iff (reset) // R1
    (aux_req && aux_use_ptr) |-> !ext_we) else $error("pointer access wrote extended register");
  a_ptr_ram_hit: assert property (@(posedge clk_sys) disable iff (reset) // R9 R12
    (aux_req && aux_use_ptr && aux_addr < 16'(AUX_BYTES)) |-> aux_ram_hit)
    else $error("pointer access missed auxiliary RAM");
  a_aux_beyond_ram: assert property (@(posedge clk_sys) disable iff (reset) // R10
    (aux_req && (aux_use_ptr || !ext_hit) && aux_addr >= 16'(AUX_BYTES)) |=> aux_rdata == 8'h00)
    else $error("unmapped auxiliary read not zero");
  a_aux_idle_zero: assert property (@(posedge clk_sys) disable iff (reset)
    !aux_req |=> aux_rdata == 8'h00) else $error("idle auxiliary read not zero");
  a_code_beyond: assert property (@(posedge clk_sys) disable iff (reset) // R11
    (code_req && code_addr >= 16'(CODE_SIZE)) |=> code_rdata == 8'hff)
    else $error("unimplemented code read not ff");
  a_ptr_addr: assert property (@(posedge clk_sys) disable iff (reset) // R9
    (aux_req && aux_use_ptr) |-> aux_addr == {aux_page, (aux_ptr_sel ? pointer_reg1 : pointer_reg0)})
    else $error("pointer register address wrong");
  a_ext_read: assert property (@(posedge clk_sys) disable iff (reset) // R1
    (aux_req && !aux_use_ptr && ext_hit) |=> aux_rdata == $past(ext_rdata))
    else $error("extended read wrong");
  a_out_copy: assert property (@(posedge clk_sys) disable iff (reset) // R2 R3 R4
    1'b1 |=> {clock_control_reg, temp_sensor_ctrl, bod_irq_trip_cfg} == $past({ext_ccr, ext_tps, ext_bod}))
    else $error("register outputs not one cycle behind the bank");
  a_pin_agree: assert property (@(posedge clk_sys) disable iff (reset)
    (pin_s2_q == pin_s3_q) |=> pin_q == $past(pin_s3_q)) else $error("status change not taken");
  c_sfr_direct: cover property (@(posedge clk_sys) disable iff (reset) sfr_sel_d);
  c_ptr_ram: cover property (@(posedge clk_sys) disable iff (reset) aux_ram_hit && aux_use_ptr);
  c_ext_write: cover property (@(posedge clk_sys) disable iff (reset) ext_we && ext_hit);
  c_aux_ram: cover property (@(posedge clk_sys) disable iff (reset) aux_ram_hit && aux_we);
  c_code_read: cover property (@(posedge clk_sys) disable iff (reset) code_ok && !code_we);
endmodule

//--- core/msx_pkg.sv
// Purpose: Shared constants for the memory space decoder and extended registers.
// Assumes: 8-bit data, 16-bit auxiliary and code addresses.
// Notes: Offsets are byte addresses in the auxiliary data space.
package msx_pkg;
  localparam logic [15:0] RTC_DATA_LOW_OFF   = 16'hffbe;
  localparam logic [15:0] RTC_DATA_HIGH_OFF  = 16'hffbf;
  localparam logic [15:0] BROWNOUT_CFG_OFF   = 16'hffc8;
  localparam logic [15:0] TEMP_SENSOR_OFF    = 16'hffca;
  localparam logic [15:0] CLOCK_CONTROL_OFF  = 16'hffde;
  localparam logic [7:0]  RTC_RESET          = 8'h00;
  localparam logic [7:0]  TEMP_RESET         = 8'h00;
  localparam logic [7:0]  TEMP_MASK          = 8'h0c;
  localparam logic [7:0]  BROWNOUT_MASK      = 8'h03;
  localparam logic [7:0]  CLOCK_WR_MASK      = 8'h0f;
  localparam int          USER_CONFIG_BYTE1_BOI_HI_BIT   = 5;
  localparam int          USER_CONFIG_BYTE1_BOI_LO_BIT   = 3;
  localparam int          USER_CONFIG_BYTE2_DOUBLER_BIT  = 7;
  localparam int          CLK_DOUBLER_BIT    = 3;
  localparam int          CLK_OK_BIT         = 7;
  localparam int          CLK_XTAL_WD_BIT    = 4;
  localparam int          AUX_RAM_BYTES      = 512;
  localparam int          IRAM_BYTES         = 256;
  localparam int          CODE_BYTES         = 16384;
endpackage

//--- core/msx_ext_regs.sv
// Purpose: Extended register bank decoded inside the auxiliary data space.
// Assumes: Power-on flag marks a power-on reset, config bytes stable at release.
// Notes: Configuration bits are loaded on the first clock after reset release, trip bits only if por_flag is set.
`timescale 1ns/1ps
module msx_ext_regs (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        por_flag,
  input  wire logic [7:0]  user_config_byte1,
  input  wire logic [7:0]  user_config_byte2,
  input  wire logic        clk_ok,
  input  wire logic        xtal_wd,
  input  wire logic [15:0] addr,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wdata,
  output logic             hit,
  output logic [7:0]       rdata,
  output logic [7:0]       clock_control_reg,
  output logic [7:0]       temp_sensor_ctrl,
  output logic [1:0]       bod_irq_trip_cfg
);
  logic [7:0] rtc_lo_q, rtc_lo_d, rtc_hi_q, rtc_hi_d, tps_q, tps_d;
  logic [1:0] bod_q, bod_d;
  logic [4:0] clk_q, clk_d;
  logic       load_q, load_d;

  always_comb
  begin
    hit = 1'b1;
    rdata = 8'h00;
    unique case (addr)
      msx_pkg::RTC_DATA_LOW_OFF:  rdata = rtc_lo_q;
      msx_pkg::RTC_DATA_HIGH_OFF: rdata = rtc_hi_q;
      msx_pkg::BROWNOUT_CFG_OFF:  rdata = {6'h00, bod_q};
      msx_pkg::TEMP_SENSOR_OFF:   rdata = tps_q;
      msx_pkg::CLOCK_CONTROL_OFF: rdata = {clk_ok, 2'h0, xtal_wd, clk_q[3:0]};
      default:                    hit = 1'b0;
    endcase
  end

  always_comb
  begin
    load_d = 1'b0;
    rtc_lo_d = rtc_lo_q;
    rtc_hi_d = rtc_hi_q;
    tps_d = tps_q;
    bod_d = bod_q;
    clk_d = clk_q;
    if (load_q)
    begin
      clk_d = {1'b0, user_config_byte2[msx_pkg::USER_CONFIG_BYTE2_DOUBLER_BIT], user_config_byte1[2:0]}; // R3 R4
      if (por_flag)
        bod_d = {user_config_byte1[msx_pkg::USER_CONFIG_BYTE1_BOI_HI_BIT], user_config_byte1[msx_pkg::USER_CONFIG_BYTE1_BOI_LO_BIT]}; // R2
    end
    else if (wr_en && hit) // R1
    begin
      unique case (addr)
        msx_pkg::RTC_DATA_LOW_OFF:  rtc_lo_d = wdata;
        msx_pkg::RTC_DATA_HIGH_OFF: rtc_hi_d = wdata;
        msx_pkg::BROWNOUT_CFG_OFF:  bod_d = wdata[1:0];
        msx_pkg::TEMP_SENSOR_OFF:   tps_d = wdata & msx_pkg::TEMP_MASK;
        msx_pkg::CLOCK_CONTROL_OFF: clk_d = 5'(wdata & msx_pkg::CLOCK_WR_MASK);
        default:                    clk_d = clk_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      load_q <= 1'b1;
      rtc_lo_q <= msx_pkg::RTC_RESET;
      rtc_hi_q <= msx_pkg::RTC_RESET;
      tps_q <= msx_pkg::TEMP_RESET;
      bod_q <= 2'h0;
      clk_q <= 5'h00;
    end
    else
    begin
      load_q <= load_d;
      rtc_lo_q <= rtc_lo_d;
      rtc_hi_q <= rtc_hi_d;
      tps_q <= tps_d;
      bod_q <= bod_d;
      clk_q <= clk_d;
    end
  end

  assign clock_control_reg = {clk_ok, 2'h0, xtal_wd, clk_q[3:0]};
  assign temp_sensor_ctrl = tps_q;
  assign bod_irq_trip_cfg = bod_q;

  a_cfg_load_clk: assert property (@(posedge clk_sys) disable iff (reset) // R3
    load_q |=> clk_q[2:0] == $past(user_config_byte1[2:0])) else $error("osc select not loaded");
  a_cfg_load_dbl: assert property (@(posedge clk_sys) disable iff (reset) // R4
    load_q |=> clk_q[3] == $past(user_config_byte2[7])) else $error("doubler not loaded");
  a_cfg_load_bod: assert property (@(posedge clk_sys) disable iff (reset) // R2
    (load_q && por_flag) |=> bod_q == {$past(user_config_byte1[5]), $past(user_config_byte1[3])})
    else $error("trip config not loaded");
  a_ext_write: assert property (@(posedge clk_sys) disable iff (reset) // R1
    (!load_q && wr_en && addr == msx_pkg::RTC_DATA_LOW_OFF) |=> rtc_lo_q == $past(wdata))
    else $error("extended write lost");
endmodule

//--- sim/msx_core_model.sv
// Purpose: Core-side model issuing internal, auxiliary and code accesses.
// Assumes: Data is sampled 1 ns after the edge that takes the request.
// Notes: Released address and data lines show inverted values.
`timescale 1ns/1ps
module msx_core_model (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  iram_rdata,
  input  wire logic [7:0]  aux_rdata,
  input  wire logic [7:0]  code_rdata,
  output logic             iram_req,
  output logic             iram_indirect,
  output logic             iram_we,
  output logic [7:0]       iram_addr,
  output logic [7:0]       iram_wdata,
  output logic             aux_req,
  output logic             aux_we,
  output logic             aux_use_ptr,
  output logic             aux_ptr_sel,
  output logic [15:0]      data_pointer,
  output logic [7:0]       pointer_reg0,
  output logic [7:0]       pointer_reg1,
  output logic [7:0]       aux_page,
  output logic [7:0]       aux_wdata,
  output logic             code_req,
  output logic             code_we,
  output logic [15:0]      code_addr,
  output logic [7:0]       code_wdata
);
  initial
  begin
    {iram_req, iram_indirect, iram_we, iram_addr, iram_wdata, aux_req, aux_we, aux_use_ptr} = '0;
    {aux_ptr_sel, data_pointer, pointer_reg0, pointer_reg1, aux_page, aux_wdata} = '0;
    {code_req, code_we, code_addr, code_wdata} = '0;
  end

  // The alt flag picks indirect mode and pointer register 1; the other pointer holds a wrong value.
  task automatic op(input logic [1:0] sp, input logic we, input logic alt, input logic ptr,
                    input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    {iram_req, aux_req, code_req} <= {sp == 2'h0, sp == 2'h1, sp == 2'h2};
    {iram_we, aux_we, code_we} <= {3{we}};
    {iram_indirect, aux_ptr_sel, aux_use_ptr} <= {alt, alt, ptr};
    {iram_addr, data_pointer, code_addr} <= {a[7:0], a, a};
    {aux_page, pointer_reg0, pointer_reg1} <= {a[15:8], alt ? ~a[7:0] : a[7:0], alt ? a[7:0] : ~a[7:0]};
    {iram_wdata, aux_wdata, code_wdata} <= {3{d}};
    @(posedge clk_sys);
    {iram_req, aux_req, code_req} <= 3'h0;
    {iram_addr, data_pointer, code_addr} <= ~{a[7:0], a, a};
    {iram_wdata, aux_wdata, code_wdata} <= ~{3{d}};
    #1;
    q = (sp == 2'h0) ? iram_rdata : (sp == 2'h1) ? aux_rdata : code_rdata;
  endtask
endmodule

//--- sim/tb_top.sv
// Purpose: Self-checking bench for the memory space decoder.
// Assumes: Code space parameter shortened to 4096 bytes.
// Notes: Random data comes from an 8-bit shift register seeded with 46.
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] EOFF [5] = '{16'hffbe, 16'hffbf, 16'hffc8, 16'hffca, 16'hffde};
  localparam logic [7:0]  EMSK [5] = '{8'hff, 8'hff, 8'h03, 8'h0c, 8'h0f};
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        por_flag = 1'b1;
  logic        clk_ok = 1'b1;
  logic        xtal_wd = 1'b0;
  logic [7:0]  user_config_byte1 = 8'h00;
  logic [7:0]  user_config_byte2 = 8'h00;
  logic [7:0]  seed = 8'h2e;
  logic [7:0]  iram_rdata, aux_rdata, code_rdata, iram_addr, iram_wdata, pointer_reg0, pointer_reg1;
  logic [7:0]  aux_page, aux_wdata, code_wdata, clock_control_reg, temp_sensor_ctrl, q;
  logic [7:0]  wv [5];
  logic [15:0] data_pointer, code_addr, a;
  logic [1:0]  bod_irq_trip_cfg;
  logic        sfr_sel, iram_req, iram_indirect, iram_we, aux_req, aux_we, aux_use_ptr, aux_ptr_sel;
  logic        code_req, code_we;
  int          n_fail = 0;
  int          n_checks = 0;

  always #12.5 clk_sys = ~clk_sys;

  msx_mem_space #(.CODE_SIZE(4096)) dut_u (.clk_sys, .reset, .por_flag, .user_config_byte1,
    .user_config_byte2, .clk_ok, .xtal_wd, .iram_req, .iram_indirect, .iram_we, .iram_addr,
    .iram_wdata, .iram_rdata, .sfr_sel, .aux_req, .aux_we, .aux_use_ptr, .aux_ptr_sel,
    .data_pointer, .pointer_reg0, .pointer_reg1, .aux_page, .aux_wdata, .aux_rdata, .code_req,
    .code_we, .code_addr, .code_wdata, .code_rdata, .clock_control_reg, .temp_sensor_ctrl,
    .bod_irq_trip_cfg);

  msx_core_model core_u (.clk_sys, .iram_rdata, .aux_rdata, .code_rdata, .iram_req, .iram_indirect,
    .iram_we, .iram_addr, .iram_wdata, .aux_req, .aux_we, .aux_use_ptr, .aux_ptr_sel, .data_pointer,
    .pointer_reg0, .pointer_reg1, .aux_page, .aux_wdata, .code_req, .code_we, .code_addr, .code_wdata);

  function automatic logic [7:0] nxt(input logic [7:0] s);
    nxt = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [7:0] ext_exp(input int i, input logic [7:0] d);
    ext_exp = (d & EMSK[i]) | ((i == 4) ? {clk_ok, 2'h0, xtal_wd, 4'h0} : 8'h00);
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test;
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Holds reset for 20 cycles with fresh configuration bytes, then checks the loaded bits.
  task automatic do_reset(input logic por);
    @(posedge clk_sys);
    seed = nxt(seed);
    {reset, por_flag, user_config_byte1, xtal_wd, clk_ok} <= {1'b1, por, seed, seed[6], seed[5]};
    seed = nxt(seed);
    user_config_byte2 <= seed;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    check("clock_ctrl", clock_control_reg, {clk_ok, 2'h0, xtal_wd, user_config_byte2[7], user_config_byte1[2:0]});
    check("bod_cfg", {6'h0, bod_irq_trip_cfg}, por ? {6'h0, user_config_byte1[5], user_config_byte1[3]} : 8'h00);
  endtask

  initial
  begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    finish_test();
  end

  initial
  begin
    do_reset(1'b1);
    do_reset(1'b0);
    core_u.op(2'h1, 1'b1, 1'b0, 1'b0, 16'h01be, 8'ha5, q);
    for (int i = 0; i < 5; i++)
    begin
      seed = nxt(seed);
      wv[i] = seed;
      core_u.op(2'h1, 1'b1, 1'b0, 1'b0, EOFF[i], wv[i], q);
      core_u.op(2'h1, 1'b0, 1'b0, 1'b0, EOFF[i], 8'h00, q);
      check("ext_reg", q, ext_exp(i, wv[i]));
    end
    repeat (3) @(posedge clk_sys);
    #1;
    check("bod_out", {6'h0, bod_irq_trip_cfg}, wv[2] & 8'h03);
    check("temp_out", temp_sensor_ctrl, wv[3] & 8'h0c);
    check("clk_out", clock_control_reg, ext_exp(4, wv[4]));
    core_u.op(2'h1, 1'b0, 1'b0, 1'b0, 16'h01be, 8'h00, q);
    check("aux_alias", q, 8'ha5);
    core_u.op(2'h1, 1'b1, 1'b0, 1'b1, 16'hffbe, ~wv[0], q);
    core_u.op(2'h1, 1'b0, 1'b1, 1'b1, 16'hffbe, 8'h00, q);
    check("ptr_ext", q, 8'h00);
    core_u.op(2'h1, 1'b0, 1'b0, 1'b0, 16'hffbe, 8'h00, q);
    check("ext_kept", q, wv[0]);
    core_u.op(2'h1, 1'b0, 1'b0, 1'b0, 16'h0200, 8'h00, q);
    check("aux_beyond", q, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      seed = nxt(seed);
      a = {7'h00, seed[0], nxt(seed)};
      core_u.op(2'h1, 1'b1, seed[1], 1'b1, a, seed, q);
      core_u.op(2'h1, 1'b0, 1'b0, 1'b0, a, 8'h00, q);
      check("aux_ram", q, seed);
    end
    core_u.op(2'h0, 1'b1, 1'b0, 1'b0, 16'h0012, 8'h3c, q);
    core_u.op(2'h0, 1'b0, 1'b1, 1'b0, 16'h0012, 8'h00, q);
    check("iram_low", q, 8'h3c);
    core_u.op(2'h0, 1'b1, 1'b1, 1'b0, 16'h0090, 8'h5a, q);
    core_u.op(2'h0, 1'b1, 1'b0, 1'b0, 16'h0090, 8'hc3, q);
    check("sfr_sel", {7'h0, sfr_sel}, 8'h01);
    core_u.op(2'h0, 1'b0, 1'b1, 1'b0, 16'h0090, 8'h00, q);
    check("iram_high", q, 8'h5a);
    check("sfr_sel_ind", {7'h0, sfr_sel}, 8'h00);
    core_u.op(2'h0, 1'b0, 1'b0, 1'b0, 16'h0090, 8'h00, q);
    check("direct_high", q, 8'h00);
    core_u.op(2'h2, 1'b1, 1'b0, 1'b0, 16'h0abc, 8'h77, q);
    core_u.op(2'h2, 1'b0, 1'b0, 1'b0, 16'h0abc, 8'h00, q);
    check("code_rd", q, 8'h77);
    core_u.op(2'h2, 1'b0, 1'b0, 1'b0, 16'h1000, 8'h00, q);
    check("code_beyond", q, 8'hff);
    finish_test();
  end
endmodule
